// ===== smw_pkg.sv
// package of register map, field positions and mode types for sleep/wake control
package smw_pkg;
  // =====================================
  // register byte addresses
  localparam logic [31:0] SMW_ADDR_CLKEN   = 32'h4000_0008;
  localparam logic [31:0] SMW_ADDR_FLAGS   = 32'h4000_A014;
  localparam logic [31:0] SMW_ADDR_MASK    = 32'h4000_A054;
  localparam logic [31:0] SMW_ADDR_CMPBH   = 32'h4000_6020;
  localparam logic [31:0] SMW_ADDR_CMPBL   = 32'h4000_6024;
  localparam logic [31:0] SMW_ADDR_TMRCFG  = 32'h4000_6000;
  localparam logic [31:0] SMW_ADDR_WAKECR  = 32'h4000_0010;
  localparam logic [31:0] SMW_ADDR_WAKEREC = 32'h4000_0014;
  localparam logic [31:0] SMW_ADDR_PWRSTAT = 32'h4000_0018;
  // =====================================
  // field positions
  localparam int SMW_BIT_WRAP     = 0;
  localparam int SMW_BIT_CMPA     = 1;
  localparam int SMW_BIT_CMPB     = 2;
  localparam int SMW_BIT_XTAL     = 0;
  localparam int SMW_BIT_RCKEEP   = 1;
  localparam int SMW_BIT_TMR_EN   = 11;
  localparam int SMW_BIT_WAKECORE = 0;
  // wake record bits
  localparam int SMW_WR_GPIO   = 0;
  localparam int SMW_WR_SC1    = 1;
  localparam int SMW_WR_SC2    = 2;
  localparam int SMW_WR_EXTD   = 3;
  localparam int SMW_WR_DBGPWR = 4;
  localparam int SMW_WR_SYSPWR = 5;
  localparam int SMW_WR_CMPA   = 6;
  localparam int SMW_WR_CMPB   = 7;
  localparam int SMW_WR_WRAP   = 8;
  localparam int SMW_WR_CORE   = 9;
  localparam int SMW_WR_W      = 10;
  // =====================================
  // reset values
  localparam logic [1:0]  SMW_RST_CLKEN = 2'h2;
  localparam logic [15:0] SMW_RST_CMPB  = 16'hFFFF;
  localparam logic [2:0]  SMW_RST_IRQ   = 3'h0;
  // =====================================
  // power modes
  typedef enum logic [2:0] {
    SMW_RUN, SMW_IDLE, SMW_PRE_DEEP, SMW_DEEP0, SMW_DEEP1, SMW_DEEP2
  } smw_mode_t;
endpackage

// ===== smw_sleep_wake.sv
// sleep entry, wake source gating, wake recording and sleep timer irq registers
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module smw_sleep_wake
  import smw_pkg::*;
#(
  parameter int GPIO_W = 24,
  parameter int SC1_PIN = 10,
  parameter int SC2_PIN = 2
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              sleep_wfi,
  input  wire logic              deep_request_bit,
  input  wire logic              cpu_irq_pending,
  input  wire logic [GPIO_W-1:0] gpio_in,
  input  wire logic              routable_ext_irq_d,
  input  wire logic              dbg_pwrup_req,
  input  wire logic              sys_pwrup_req,
  input  wire logic              match_a_event,
  input  wire logic              match_b_event,
  input  wire logic              counter_wrap_event,
  output logic                   cpu_halt,
  output logic                   core_power_off,
  output logic                   periph_reset,
  output logic                   core_reset,
  output logic                   sleep_timer_run,
  output logic                   low_freq_rc_osc,
  output logic                   xtal_osc_enable,
  output logic                   timer_irq,
  output logic [31:0]            match_b_value,
  output logic                   wake_pulse
);
  // refuse pin indices the synchroniser cannot serve
  if (GPIO_W < 1 || SC1_PIN < 0 || SC1_PIN >= GPIO_W ||
      SC2_PIN < 0 || SC2_PIN >= GPIO_W) begin : g_bad_params
    $error("smw_sleep_wake: bad pin parameters");
  end

  // =====================================
  // pin synchronisers
  // only the second stage and its delayed copy feed logic; the first may be metastable
  localparam int SYNC_W = GPIO_W + 3;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] prev_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= {sys_pwrup_req, dbg_pwrup_req, routable_ext_irq_d, gpio_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  logic              dbg_s;
  logic              sys_s;
  logic [SYNC_W-1:0] edge_s;
  // edges masked until the chain refills after reset,
  // else a pin idling high would look like a wake edge
  logic [1:0]        settle_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      settle_q <= 2'h0;
    end else if (!(&settle_q)) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  assign dbg_s  = sync2_q[GPIO_W+1];
  assign sys_s  = sync2_q[GPIO_W+2];
  assign edge_s = (sync2_q ^ prev_q) & {SYNC_W{&settle_q}};

  // =====================================
  // apb slave, zero wait states
  logic wr_en;
  logic rd_en;
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;

  function automatic logic addr_known(input logic [31:0] a);
    return a == SMW_ADDR_CLKEN || a == SMW_ADDR_FLAGS || a == SMW_ADDR_MASK ||
           a == SMW_ADDR_CMPBH || a == SMW_ADDR_CMPBL || a == SMW_ADDR_TMRCFG ||
           a == SMW_ADDR_WAKECR || a == SMW_ADDR_WAKEREC || a == SMW_ADDR_PWRSTAT;
  endfunction
  assign pslverr = psel && penable && !addr_known(paddr);

  // =====================================
  // compare b with low-half hold
  logic [15:0] cmpb_hold_q;
  logic [15:0] cmpb_lo_q;
  logic [15:0] cmpb_hi_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      cmpb_hold_q <= SMW_RST_CMPB;
      cmpb_lo_q   <= SMW_RST_CMPB;
      cmpb_hi_q   <= SMW_RST_CMPB;
    end else if (wr_en && paddr == SMW_ADDR_CMPBL) begin
      cmpb_hold_q <= pwdata[15:0];
    end else if (wr_en && paddr == SMW_ADDR_CMPBH) begin
      cmpb_hi_q <= pwdata[15:0];
      cmpb_lo_q <= cmpb_hold_q;
    end
  end
  assign match_b_value = {cmpb_hi_q, cmpb_lo_q};

  // timer enable shadow, read back so software can honour the change window
  logic tmr_en_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      tmr_en_q <= 1'b0;
    end else if (wr_en && paddr == SMW_ADDR_TMRCFG) begin
      tmr_en_q <= pwdata[SMW_BIT_TMR_EN];
    end
  end

  // =====================================
  // irq flags and mask
  logic [2:0] flags_q;
  logic [2:0] mask_q;
  logic [2:0] evt;
  logic [2:0] clr;
  assign evt = {match_b_event, match_a_event, counter_wrap_event};
  assign clr = (wr_en && paddr == SMW_ADDR_FLAGS) ? pwdata[2:0] : 3'h0;
  // set wins over a same-cycle write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_q <= SMW_RST_IRQ;
    end else begin
      flags_q <= (flags_q & ~clr) | evt;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      mask_q <= SMW_RST_IRQ;
    end else if (wr_en && paddr == SMW_ADDR_MASK) begin
      mask_q <= pwdata[2:0];
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(flags_q & mask_q);
    end
  end

  // =====================================
  // clock source enables
  logic [1:0] clken_q;
  logic       wake;
  // a wake beats a same-cycle software write
  always_ff @(posedge clock) begin
    if (rst) begin
      clken_q <= SMW_RST_CLKEN;
    end else if (wake) begin
      clken_q[SMW_BIT_RCKEEP] <= 1'b1;
    end else if (wr_en && paddr == SMW_ADDR_CLKEN) begin
      clken_q <= pwdata[1:0];
    end
  end

  // =====================================
  // power mode machine
  smw_mode_t mode_q;
  smw_mode_t mode_d;
  logic      core_wake_w;
  logic      pin_wake;
  logic      tmr_wake;
  assign core_wake_w = wr_en && paddr == SMW_ADDR_WAKECR && pwdata[SMW_BIT_WAKECORE];
  assign pin_wake = |edge_s[GPIO_W-1:0]
                  || edge_s[SC1_PIN] || edge_s[SC2_PIN]
                  || edge_s[GPIO_W];
  assign tmr_wake = |evt;

  always_comb begin
    mode_d = mode_q;
    wake   = 1'b0;
    unique case (mode_q)
      SMW_RUN: begin
        if (sleep_wfi && deep_request_bit) begin
          mode_d = SMW_PRE_DEEP;
        end else if (sleep_wfi) begin
          mode_d = SMW_IDLE;
        end
      end
      SMW_IDLE: begin
        if (cpu_irq_pending) begin
          mode_d = SMW_RUN;
        end
      end
      SMW_PRE_DEEP: begin
        // synced request, so entry lags the pin by three edges
        if (!sys_s) begin
          if (dbg_s) begin
            mode_d = SMW_DEEP0;
          end else if (clken_q[SMW_BIT_RCKEEP]) begin
            mode_d = SMW_DEEP1;
          end else begin
            mode_d = SMW_DEEP2;
          end
        end
      end
      SMW_DEEP0: begin
        if (core_wake_w || pin_wake) begin
          wake = 1'b1;
        end
      end
      SMW_DEEP1: begin
        if (pin_wake || dbg_s || sys_s || tmr_wake) begin
          wake = 1'b1;
        end
      end
      SMW_DEEP2: begin
        if (pin_wake || dbg_s || sys_s) begin
          wake = 1'b1;
        end
      end
    endcase
    if (wake) begin
      mode_d = SMW_RUN;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= SMW_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // =====================================
  // wake recording, runs in every mode
  logic [SMW_WR_W-1:0] rec_q;
  logic [SMW_WR_W-1:0] rec_set;
  logic [SMW_WR_W-1:0] rec_clr;
  // request levels are recorded as well as edges, so a held one stays set
  always_comb begin
    rec_set = '0;
    rec_set[SMW_WR_GPIO]   = |edge_s[GPIO_W-1:0];
    rec_set[SMW_WR_SC1]    = edge_s[SC1_PIN];
    rec_set[SMW_WR_SC2]    = edge_s[SC2_PIN];
    rec_set[SMW_WR_EXTD]   = edge_s[GPIO_W];
    rec_set[SMW_WR_DBGPWR] = dbg_s;
    rec_set[SMW_WR_SYSPWR] = sys_s;
    rec_set[SMW_WR_CMPA]   = match_a_event;
    rec_set[SMW_WR_CMPB]   = match_b_event;
    rec_set[SMW_WR_WRAP]   = counter_wrap_event;
    rec_set[SMW_WR_CORE]   = core_wake_w;
  end
  assign rec_clr = (wr_en && paddr == SMW_ADDR_WAKEREC) ? pwdata[SMW_WR_W-1:0] : '0;
  always_ff @(posedge clock) begin
    if (rst) begin
      rec_q <= '0;
    end else begin
      rec_q <= (rec_q & ~rec_clr) | rec_set;
    end
  end

  // =====================================
  // power and reset outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_halt        <= 1'b0;
      core_power_off  <= 1'b0;
      periph_reset    <= 1'b0;
      core_reset      <= 1'b0;
      sleep_timer_run <= 1'b1;
      low_freq_rc_osc <= 1'b1;
      xtal_osc_enable <= 1'b0;
      wake_pulse      <= 1'b0;
    end else begin
      cpu_halt        <= mode_d != SMW_RUN;
      core_power_off  <= mode_d == SMW_DEEP1 || mode_d == SMW_DEEP2;
      periph_reset    <= mode_d == SMW_DEEP0;
      core_reset      <= wake && mode_q != SMW_DEEP0; // core comes back through reset, except when waking from SMW_DEEP0
      sleep_timer_run <= mode_d != SMW_DEEP2;
      low_freq_rc_osc <= mode_d != SMW_DEEP2;
      xtal_osc_enable <= clken_q[SMW_BIT_XTAL];
      wake_pulse      <= wake;
    end
  end

  // =====================================
  // read data
  // loaded at setup so it stands through the access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          SMW_ADDR_CLKEN:   prdata <= {30'h0, clken_q};
          SMW_ADDR_FLAGS:   prdata <= {29'h0, flags_q};
          SMW_ADDR_MASK:    prdata <= {29'h0, mask_q};
          SMW_ADDR_CMPBH:   prdata <= {16'h0, cmpb_hi_q};
          SMW_ADDR_CMPBL:   prdata <= {16'h0, cmpb_lo_q};
          SMW_ADDR_TMRCFG:  prdata <= {20'h0, tmr_en_q, 11'h0};
          SMW_ADDR_WAKEREC: prdata <= {22'h0, rec_q};
          SMW_ADDR_PWRSTAT: prdata <= {29'h0, mode_q};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule

// ===== smw_sleep_wake_assertions.sv
// port-level checks for sleep/wake control
`timescale 1ns/10ps
module smw_sleep_wake_chk
  import smw_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        dbg_pwrup_req,
  input wire logic        sys_pwrup_req,
  input wire logic        match_a_event,
  input wire logic        match_b_event,
  input wire logic        counter_wrap_event,
  input wire logic        core_power_off,
  input wire logic        periph_reset,
  input wire logic        sleep_timer_run,
  input wire logic        low_freq_rc_osc,
  input wire logic        timer_irq,
  input wire logic [31:0] match_b_value,
  input wire logic        wake_pulse
);
  // ====================================
  // helpers
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic wr_go;
  logic tmr_ev;
  assign wr_go = psel && penable && pwrite;
  assign tmr_ev = match_a_event || match_b_event || counter_wrap_event;
  sequence s_asleep;
    core_power_off && !wake_pulse;
  endsequence
  sequence s_wakes;
    ##[1:8] wake_pulse;
  endsequence
  // ====================================
  // checks
  a_cmpb_pair_load: assert property (
    $changed(match_b_value) |-> $past(wr_go && paddr == SMW_ADDR_CMPBH))
    else $error("compare b changed without high write");
  a_flag_w1c: assert property (
    wr_go && paddr == SMW_ADDR_FLAGS && pwdata[2:0] == 3'h7 && !tmr_ev |-> ##2 !timer_irq)
    else $error("irq stayed after clearing all flags");
  a_deep2_timer_off: assert property (!sleep_timer_run |-> core_power_off)
    else $error("timer stopped outside level two");
  a_deep0_core_on: assert property (periph_reset |-> !core_power_off)
    else $error("core off while peripherals held");
  a_dbg_wakes: assert property (
    s_asleep ##0 $rose(dbg_pwrup_req) |-> s_wakes)
    else $error("no wake on debug request");
  a_timer_wakes: assert property (
    s_asleep ##0 (sleep_timer_run && tmr_ev) |-> s_wakes)
    else $error("no wake on timer event");
  a_sys_idle_first: assert property (
    $rose(core_power_off) || $rose(periph_reset) |-> !$past(sys_pwrup_req, 3))
    else $error("powered down while system request set");
  a_dbg_only_deep0: assert property (
    $rose(core_power_off) |-> !$past(dbg_pwrup_req, 3))
    else $error("true deep sleep with debug request set");
  a_rc_restart: assert property (wake_pulse |-> ##[0:2] low_freq_rc_osc)
    else $error("rc oscillator not back after wake");
endmodule
bind smw_sleep_wake smw_sleep_wake_chk u_chk (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .dbg_pwrup_req(dbg_pwrup_req),
  .sys_pwrup_req(sys_pwrup_req), .match_a_event(match_a_event),
  .match_b_event(match_b_event), .counter_wrap_event(counter_wrap_event),
  .core_power_off(core_power_off), .periph_reset(periph_reset),
  .sleep_timer_run(sleep_timer_run), .low_freq_rc_osc(low_freq_rc_osc),
  .timer_irq(timer_irq), .match_b_value(match_b_value), .wake_pulse(wake_pulse));

// ===== smw_sleep_wake_tb_top.sv
// self-checking bench for sleep/wake control over apb
`timescale 1ns/10ps
module smw_sleep_wake_tb_top
  import smw_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        sleep_wfi = 1'b0;
  logic        deep_rq = 1'b0;
  logic        irq_pend = 1'b0;
  logic [23:0] gpio_in = 24'h0;
  logic        irq_d = 1'b0;
  logic        dbg = 1'b0;
  logic        sys = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic        pready, pslverr, cpu_halt, core_off, prst, core_reset;
  logic        tmr_run, rc_osc, xtal, timer_irq, wake;
  logic [31:0] prdata, cmpb, rdat;
  logic        rerr;
  // wake record per loop pass: timer events plus the source toggled, with the gpio bit also set on the SC1_PIN and SC2_PIN passes
  logic [31:0] rexp [6] = '{32'h1C1, 32'h1C3, 32'h1C5, 32'h1C8, 32'h1D0, 32'h1E0};
  int          fails = 0;
  int          tests_run = 0;
  always #12.5 clock = ~clock;
  smw_sleep_wake DUT (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sleep_wfi(sleep_wfi), .deep_request_bit(deep_rq),
    .cpu_irq_pending(irq_pend), .gpio_in(gpio_in), .routable_ext_irq_d(irq_d),
    .dbg_pwrup_req(dbg), .sys_pwrup_req(sys), .match_a_event(ev[1]),
    .match_b_event(ev[2]), .counter_wrap_event(ev[0]), .cpu_halt(cpu_halt),
    .core_power_off(core_off), .periph_reset(prst), .core_reset(core_reset),
    .sleep_timer_run(tmr_run), .low_freq_rc_osc(rc_osc), .xtal_osc_enable(xtal),
    .timer_irq(timer_irq), .match_b_value(cmpb), .wake_pulse(wake));
  // ====================================
  // tasks
  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // idle edge after each transfer keeps psel from being driven twice per step
  task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xf(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // wfi dropped after entry, so a wake does not re-enter at once
  task automatic deep(input logic [31:0] ck);
    xf(1'b1, SMW_ADDR_CLKEN, ck);
    sleep_wfi <= 1'b1;
    deep_rq <= 1'b1;
    wt(8);
    sleep_wfi <= 1'b0;
    deep_rq <= 1'b0;
    wt(2);
  endtask
  task automatic pulse(input logic [2:0] v);
    ev <= v;
    wt(1);
    ev <= 3'h0;
  endtask
  task automatic woke(input logic cr);
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 40) begin
      n++;
      @(posedge clock);
    end
    chk(wake, 1'b1);
    chk(core_reset, cr);
    wt(3);
    chk({core_off, prst}, 2'h0);
  endtask
  // ====================================
  // watchdog
  initial begin
    wt(20000);
    fails++;
    end_of_test();
  end
  // ====================================
  // tests
  initial begin
    wt(3);
    rst <= 1'b0;
    wt(1);
    chk(cmpb, 32'hFFFF_FFFF);
    rd(SMW_ADDR_CLKEN, 32'h2);
    rd(SMW_ADDR_FLAGS, 32'h0);
    rd(SMW_ADDR_MASK, 32'h0);
    chk(rerr, 1'b0);
    rd(32'h4000_0FFC, 32'h0);
    chk(rerr, 1'b1);
    xf(1'b1, SMW_ADDR_TMRCFG, 32'h0);
    xf(1'b1, SMW_ADDR_CMPBL, 32'h1234);
    chk(cmpb, 32'hFFFF_FFFF);
    xf(1'b1, SMW_ADDR_CMPBH, 32'hABCD);
    chk(cmpb, 32'hABCD_1234);
    xf(1'b1, SMW_ADDR_WAKEREC, 32'h3FF);
    xf(1'b1, SMW_ADDR_MASK, 32'h7);
    rd(SMW_ADDR_MASK, 32'h7);
    for (int i = 0; i < 3; i++) begin
      pulse(3'h1 << i);
      wt(2);
      chk(timer_irq, 1'b1);
      rd(SMW_ADDR_FLAGS, 32'h1 << i);
      xf(1'b1, SMW_ADDR_FLAGS, 32'h1 << i);
      wt(1);
      chk(timer_irq, 1'b0);
    end
    pulse(3'h7);
    wt(2);
    chk(timer_irq, 1'b1);
    xf(1'b1, SMW_ADDR_FLAGS, 32'h7);
    wt(1);
    chk(timer_irq, 1'b0);
    rd(SMW_ADDR_WAKEREC, 32'h1C0);
    xf(1'b1, SMW_ADDR_MASK, 32'h0);
    sleep_wfi <= 1'b1;
    wt(6);
    chk({cpu_halt, core_off, prst}, 3'h4);
    irq_pend <= 1'b1;
    sleep_wfi <= 1'b0;
    wt(4);
    chk(cpu_halt, 1'b0);
    irq_pend <= 1'b0;
    deep(32'h3);
    chk({core_off, tmr_run, xtal}, 3'h7);
    xf(1'b1, SMW_ADDR_WAKECR, 32'h1);
    wt(6);
    chk(core_off, 1'b1);
    pulse(3'h2);
    woke(1'b1);
    sys <= 1'b1;
    deep(32'h2);
    wt(10);
    chk({core_off, prst}, 2'h0);
    sys <= 1'b0;
    wt(8);
    chk(core_off, 1'b1);
    gpio_in <= 24'h80_0000;
    woke(1'b1);
    dbg <= 1'b1;
    wt(4);
    deep(32'h2);
    chk({prst, core_off}, 2'h2);
    xf(1'b1, SMW_ADDR_WAKECR, 32'h1);
    woke(1'b0);
    dbg <= 1'b0;
    wt(4);
    for (int k = 0; k < 6; k++) begin
      xf(1'b1, SMW_ADDR_WAKEREC, 32'h3FF);
      deep(32'h0);
      chk({core_off, tmr_run, rc_osc}, 3'h4);
      pulse(3'h7);
      wt(6);
      chk(core_off, 1'b1);
      case (k)
        0: gpio_in <= gpio_in ^ 24'h1;
        1: gpio_in <= gpio_in ^ 24'h400;
        2: gpio_in <= gpio_in ^ 24'h4;
        3: irq_d <= ~irq_d;
        4: dbg <= 1'b1;
        default: sys <= 1'b1;
      endcase
      woke(1'b1);
      rd(SMW_ADDR_CLKEN, 32'h2);
      rd(SMW_ADDR_WAKEREC, rexp[k]);
      dbg <= 1'b0;
      sys <= 1'b0;
      wt(6);
    end
    end_of_test();
  end
endmodule
